// [src/hbm_cfg.svh]
`ifndef HBM_CFG_SVH
`define HBM_CFG_SVH
// ==========================================
// Register map
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_CONS_BASE   12'h010
// ==========================================
// Field positions
`define CTRL_PROD_MSB   15
`define CTRL_BEH_LSB    16
`define CONS_NODE_LSB   16
// ==========================================
// Reset values
`define CTRL_RST        32'h0000_0000
`define CONS_RST        32'h0000_0000
// ==========================================
// Node state codes
`define ST_PREOP_CODE   8'h7F
`define ST_OPER_CODE    8'h05
`define ST_STOP_CODE    8'h04
// ==========================================
// Error behaviour values
`define BEH_PREOP       2'h0
`define BEH_KEEP        2'h1
`define BEH_STOP        2'h2
// ==========================================
// Emergency codes
`define EC_CLEAR        16'h0000
`define EC_GENERIC      16'h5000
`define EC_SYNC         16'h8100
`define EC_CANOVF       16'h8110
`define EC_PASSIVE      16'h8120
`define EC_LIFE         16'h8130
`define EC_PDO_SHORT    16'h8210
`define EC_PDO_LONG     16'h8220
`define EC_DEVICE       16'hFF00
`define ER_COMM         8'h11
`define ER_GEN          8'h81
`define AC_DIAG_TAG     8'h07
// ==========================================
// Timing
`define CLK_PERIOD_NS   25
`define MS_TIME_NS      1000000
`endif

// [src/hbm_pkg.sv]
package hbm_pkg;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    ST_PREOP = 2'b00,
    ST_OPER  = 2'b01,
    ST_STOP  = 2'b11
  } nmt_state_t;

  typedef struct packed {
    logic defaults_loaded;
    logic flash_fail;
    logic cfg_mismatch;
    logic emcy_queue_ovf;
    logic gateway_ovf;
    logic mailbox_ovf;
    logic sync_timeout;
    logic sync_resume;
    logic rx_buf_ovf;
    logic tx_buf_ovf;
    logic err_passive;
    logic guard_fail;
    logic guard_resume;
    logic pdo_short;
    logic pdo_long;
    logic modbus_err;
    logic diag;
  } emcy_evt_t;

  typedef struct packed {
    logic [7:0] physical_slot_position;
    logic [7:0] logical_slot_position;
    logic [7:0] mismatch_cause;
    logic [7:0] configured_len;
    logic [7:0] received_byte_count;
    logic [7:0] pdo_or_error_count;
    logic [7:0] diagnosis_byte;
    logic [7:0] fault_status_channel;
  } emcy_info_t;

  typedef struct packed {
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;
endpackage : hbm_pkg

// [src/hb_emcy.sv]
`timescale 1ns/1ps
`include "hbm_cfg.svh"
// Behaviour
// - Send heartbeat at producer interval, immediately
// - State codes 127 preop, 5 oper, 4 stop
// - Up to five consumer nodes supervised
// - Each node armed by its first heartbeat
// - Timeout: blink, emergency 8130/11/00 05 node
// - Timeout: error outputs, state per behaviour
// - Resume: clearing emergency, state and error outputs unchanged
// - Blink holds until last failed node resumes
// - Nonzero producer time disables node guarding
// - Emergency bytes: code low first, register, additional
// - Cleared condition sends code 0000, same fields
// - Default settings at power-up: 5000/81/00 01
// - Flash save failure: 5000/81/00 02
// - Configuration mismatch: 00 03 slots, cause
// - Overflows: 00 09, 00 0A 01, 00 0A 02
// - Sync timeout: 8100/81/00 04
// - CAN buffer overflow 8110, state, outputs
// - Error passive: 8120/11/00 03
// - Guarding lifetime exceeded: 8130/11/00 04
// - Short PDO: 8210/81/00 05 lengths, number
// - Long PDO: 8220/81/00 08 lengths, number
// - Module bus error: stop, FF00 00 06
// - Diagnosis: FF00 with diagnosis fields
module hb_emcy #(
  parameter int unsigned TICK_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned NODES       = 5
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire hbm_pkg::ahb_req_t ahb_i,
  input  wire logic [31:0]       hwdata_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  input  wire logic              hb_rx_valid_i,
  input  wire logic [6:0]        hb_rx_node_i,
  output logic                   hb_tx_valid_o,
  output logic [7:0]             hb_tx_state_o,
  input  wire logic              hb_tx_ready_i,
  input  wire hbm_pkg::emcy_evt_t evt_i,
  input  wire hbm_pkg::emcy_info_t info_i,
  output logic                   emcy_valid_o,
  output logic [63:0]            emcy_data_o,
  input  wire logic              emcy_ready_i,
  input  wire logic              nmt_cmd_valid_i,
  input  wire hbm_pkg::nmt_state_t nmt_cmd_i,
  output logic [1:0]             nmt_state_o,
  output logic                   err_outputs_o,
  output logic                   hb_blink_o,
  output logic                   guarding_en_o
);
  import hbm_pkg::*;

  if (NODES < 1 || NODES > 5) begin : g_chk
    $error("NODES must lie in 1..5");
  end
  if (TICK_CYCLES < 2) begin : g_chk2
    $error("TICK_CYCLES too small");
  end

  localparam int NE = 17;

  function automatic logic [63:0] frame(input logic [15:0] code, input logic [7:0] er,
                                        input logic [39:0] ac);
    frame = {ac[7:0], ac[15:8], ac[23:16], ac[31:24], ac[39:32], er, code[15:8], code[7:0]};
  endfunction : frame

  function automatic logic [7:0] state_code(input nmt_state_t s);
    case (s)
      ST_OPER: state_code = `ST_OPER_CODE;
      ST_STOP: state_code = `ST_STOP_CODE;
      default: state_code = `ST_PREOP_CODE;
    endcase
  endfunction : state_code

  // ==========================================
  // Bus slave
  logic [31:0]      ctrl_reg;
  logic [31:0]      cons_reg [NODES];
  logic [11:0]      addr_reg;
  logic             wr_reg;
  logic             dph_reg;
  logic [NODES-1:0] armed_reg;
  logic [NODES-1:0] failed_reg;
  nmt_state_t       state_reg;
  logic             prod_wr;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dph_reg     <= 1'b0;
      addr_reg    <= 12'h000;
      wr_reg      <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (!dph_reg && ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready) begin
      dph_reg     <= 1'b1;
      addr_reg    <= ahb_i.haddr;
      wr_reg      <= ahb_i.hwrite;
      hreadyout_o <= 1'b0;
    end else begin
      dph_reg     <= 1'b0;
      hreadyout_o <= 1'b1;
    end
  end

  assign prod_wr = dph_reg && wr_reg && addr_reg == `REG_CTRL;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `CTRL_RST;
      for (int i = 0; i < NODES; i++) cons_reg[i] <= `CONS_RST;
    end else if (dph_reg && wr_reg) begin
      if (addr_reg == `REG_CTRL) begin
        ctrl_reg <= {14'h0000, hwdata_i[17:0]};
      end else begin
        for (int i = 0; i < NODES; i++)
          if (addr_reg == `REG_CONS_BASE + 12'(4 * i)) cons_reg[i] <= {9'h000, hwdata_i[22:0]};
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (dph_reg && !wr_reg) begin
      hrdata_o <= 32'h0000_0000;
      if (addr_reg == `REG_CTRL) begin
        hrdata_o <= ctrl_reg;
      end else if (addr_reg == `REG_STATUS) begin
        hrdata_o <= {6'h00, hb_blink_o, guarding_en_o, 3'h0, 5'(armed_reg),
                     3'h0, 5'(failed_reg), state_code(state_reg)};
      end else begin
        for (int i = 0; i < NODES; i++)
          if (addr_reg == `REG_CONS_BASE + 12'(4 * i)) hrdata_o <= cons_reg[i];
      end
    end
  end

  // ==========================================
  // Millisecond tick
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
  logic                            tick;

  assign tick = tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) tick_cnt_reg <= '0;
    else if (tick) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  // ==========================================
  // Heartbeat producer
  logic [15:0] prod_cnt_reg;
  logic [15:0] prod_time;

  assign prod_time = ctrl_reg[`CTRL_PROD_MSB:0];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prod_cnt_reg  <= 16'h0000;
      hb_tx_valid_o <= 1'b0;
      hb_tx_state_o <= `ST_PREOP_CODE;
    end else begin
      if (hb_tx_valid_o && hb_tx_ready_i) hb_tx_valid_o <= 1'b0;
      if (prod_wr) begin
        prod_cnt_reg <= 16'h0000;
        if (hwdata_i[`CTRL_PROD_MSB:0] != 16'h0000) begin
          hb_tx_valid_o <= 1'b1;
          hb_tx_state_o <= state_code(state_reg);
        end
      end else if (prod_time != 16'h0000 && tick) begin
        if (prod_cnt_reg >= prod_time - 16'h0001) begin
          prod_cnt_reg  <= 16'h0000;
          hb_tx_valid_o <= 1'b1;
          hb_tx_state_o <= state_code(state_reg);
        end else begin
          prod_cnt_reg <= prod_cnt_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) guarding_en_o <= 1'b1;
    else guarding_en_o <= prod_time == 16'h0000;
  end

  // ==========================================
  // Heartbeat consumers
  logic [15:0]      cons_cnt_reg [NODES];
  logic [NODES-1:0] fail_set;
  logic [NODES-1:0] resume_set;
  logic [2:0]       last_reg;

  always_comb begin
    fail_set   = '0;
    resume_set = '0;
    for (int i = 0; i < NODES; i++) begin
      if (hb_rx_valid_i && cons_reg[i][15:0] != 16'h0000 &&
          hb_rx_node_i == cons_reg[i][22:16]) begin
        resume_set[i] = failed_reg[i];
      end else if (armed_reg[i] && !failed_reg[i] && tick &&
                   cons_cnt_reg[i] >= cons_reg[i][15:0] - 16'h0001) begin
        fail_set[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed_reg  <= '0;
      failed_reg <= '0;
      for (int i = 0; i < NODES; i++) cons_cnt_reg[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < NODES; i++) begin
        if (cons_reg[i][15:0] == 16'h0000) begin
          armed_reg[i]  <= 1'b0;
          failed_reg[i] <= 1'b0;
        end else if (hb_rx_valid_i && hb_rx_node_i == cons_reg[i][22:16]) begin
          armed_reg[i]    <= 1'b1;
          failed_reg[i]   <= 1'b0;
          cons_cnt_reg[i] <= 16'h0000;
        end else if (fail_set[i]) begin
          failed_reg[i] <= 1'b1;
        end else if (armed_reg[i] && !failed_reg[i] && tick) begin
          cons_cnt_reg[i] <= cons_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_reg   <= 3'h0;
      hb_blink_o <= 1'b0;
    end else begin
      for (int i = 0; i < NODES; i++) begin
        if (fail_set[i]) begin
          last_reg   <= 3'(i);
          hb_blink_o <= 1'b1;
        end
      end
      if (fail_set == '0 && resume_set[last_reg]) hb_blink_o <= 1'b0;
    end
  end

  // ==========================================
  // Node state and error reaction
  logic err_act;

  assign err_act = (|fail_set) || evt_i.rx_buf_ovf || evt_i.tx_buf_ovf;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg     <= ST_PREOP;
      err_outputs_o <= 1'b0;
    end else begin
      err_outputs_o <= err_act;
      if (evt_i.modbus_err) begin
        state_reg <= ST_STOP;
      end else if (err_act) begin
        if (ctrl_reg[`CTRL_BEH_LSB +: 2] == `BEH_STOP) state_reg <= ST_STOP;
        else if (ctrl_reg[`CTRL_BEH_LSB +: 2] == `BEH_PREOP && state_reg == ST_OPER)
          state_reg <= ST_PREOP;
      end else if (nmt_cmd_valid_i) begin
        state_reg <= nmt_cmd_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) nmt_state_o <= ST_PREOP;
    else nmt_state_o <= state_reg;
  end

  // ==========================================
  // Emergency pending and payloads
  logic [NE-1:0]    pend_reg;
  logic [NE-1:0]    pend_clr;
  logic [NODES-1:0] hbf_pend_reg;
  logic [NODES-1:0] hbr_pend_reg;
  logic [NODES-1:0] hbf_clr;
  logic [NODES-1:0] hbr_clr;
  emcy_info_t       cfg_info_reg;
  emcy_info_t       pdo_s_reg;
  emcy_info_t       pdo_l_reg;
  emcy_info_t       mod_info_reg;
  emcy_info_t       diag_info_reg;
  logic [63:0]      frm;
  logic             frm_ok;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_reg     <= '0;
      hbf_pend_reg <= '0;
      hbr_pend_reg <= '0;
    end else begin
      pend_reg     <= (pend_reg & ~pend_clr) | evt_i;
      hbf_pend_reg <= (hbf_pend_reg & ~hbf_clr) | fail_set;
      hbr_pend_reg <= (hbr_pend_reg & ~hbr_clr) | resume_set;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_info_reg  <= '0;
      pdo_s_reg     <= '0;
      pdo_l_reg     <= '0;
      mod_info_reg  <= '0;
      diag_info_reg <= '0;
    end else begin
      if (evt_i.cfg_mismatch) cfg_info_reg <= info_i;
      if (evt_i.pdo_short) pdo_s_reg <= info_i;
      if (evt_i.pdo_long) pdo_l_reg <= info_i;
      if (evt_i.modbus_err) mod_info_reg <= info_i;
      if (evt_i.diag) diag_info_reg <= info_i;
    end
  end

  // Pick one pending event, heartbeat events first
  always_comb begin
    pend_clr = '0;
    hbf_clr  = '0;
    hbr_clr  = '0;
    frm      = 64'h0;
    frm_ok   = 1'b0;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (hbr_pend_reg[i]) begin
        frm_ok  = 1'b1;
        hbf_clr = '0;
        hbr_clr = '0;
        hbr_clr[i] = 1'b1;
        frm = frame(`EC_CLEAR, `ER_COMM, {16'h0005, 1'b0, cons_reg[i][22:16], 16'h0000});
      end
      if (hbf_pend_reg[i]) begin
        frm_ok  = 1'b1;
        hbf_clr = '0;
        hbr_clr = '0;
        hbf_clr[i] = 1'b1;
        frm = frame(`EC_LIFE, `ER_COMM, {16'h0005, 1'b0, cons_reg[i][22:16], 16'h0000});
      end
    end
    if (!frm_ok) begin
      for (int k = 0; k < NE; k++) begin
        if (pend_reg[k]) begin
          frm_ok   = 1'b1;
          pend_clr = '0;
          pend_clr[k] = 1'b1;
        end
      end
      // Pending bit order follows the event struct, MSB first
      if (pend_clr[16]) frm = frame(`EC_GENERIC, `ER_GEN, 40'h00_01_00_00_00);
      else if (pend_clr[15]) frm = frame(`EC_GENERIC, `ER_GEN, 40'h00_02_00_00_00);
      else if (pend_clr[14])
        frm = frame(`EC_GENERIC, `ER_GEN, {16'h0003, cfg_info_reg[63:40]});
      else if (pend_clr[13]) frm = frame(`EC_GENERIC, `ER_GEN, 40'h00_09_00_00_00);
      else if (pend_clr[12]) frm = frame(`EC_GENERIC, `ER_GEN, 40'h00_0A_01_00_00);
      else if (pend_clr[11]) frm = frame(`EC_GENERIC, `ER_GEN, 40'h00_0A_02_00_00);
      else if (pend_clr[10]) frm = frame(`EC_SYNC, `ER_GEN, 40'h00_04_00_00_00);
      else if (pend_clr[9]) frm = frame(`EC_CLEAR, `ER_GEN, 40'h00_04_00_00_00);
      else if (pend_clr[8]) frm = frame(`EC_CANOVF, `ER_COMM, 40'h00_01_00_00_00);
      else if (pend_clr[7]) frm = frame(`EC_CANOVF, `ER_COMM, 40'h00_02_00_00_00);
      else if (pend_clr[6]) frm = frame(`EC_PASSIVE, `ER_COMM, 40'h00_03_00_00_00);
      else if (pend_clr[5]) frm = frame(`EC_LIFE, `ER_COMM, 40'h00_04_00_00_00);
      else if (pend_clr[4]) frm = frame(`EC_CLEAR, `ER_COMM, 40'h00_04_00_00_00);
      else if (pend_clr[3])
        frm = frame(`EC_PDO_SHORT, `ER_GEN, {16'h0005, pdo_s_reg[39:16]});
      else if (pend_clr[2])
        frm = frame(`EC_PDO_LONG, `ER_GEN, {16'h0008, pdo_l_reg[39:16]});
      else if (pend_clr[1])
        frm = frame(`EC_DEVICE, `ER_GEN, {16'h0006, mod_info_reg[63:56], 16'h0000});
      else if (pend_clr[0])
        frm = frame(`EC_DEVICE, `ER_GEN, {diag_info_reg[15:8], `AC_DIAG_TAG,
                    diag_info_reg[63:56], diag_info_reg[7:0], diag_info_reg[23:16]});
    end
    if (emcy_valid_o) begin
      pend_clr = '0;
      hbf_clr  = '0;
      hbr_clr  = '0;
    end
  end

  // ==========================================
  // Emergency output
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      emcy_valid_o <= 1'b0;
      emcy_data_o  <= 64'h0;
    end else if (emcy_valid_o) begin
      if (emcy_ready_i) emcy_valid_o <= 1'b0;
    end else if (frm_ok) begin
      emcy_valid_o <= 1'b1;
      emcy_data_o  <= frm;
    end
  end

  // ==========================================
  // Checks
  hb_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    prod_wr && hwdata_i[15:0] != 16'h0000 |=> hb_tx_valid_o)
    else $error("heartbeat not started on configuration");

  hb_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(hb_tx_valid_o) |-> hb_tx_state_o == state_code($past(state_reg)))
    else $error("heartbeat state code wrong");

  arm_first_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (failed_reg & ~armed_reg) == '0)
    else $error("node failed without being armed");

  fail_frame_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (|fail_set) && !emcy_valid_o && !frm_ok |-> ##2 emcy_valid_o
      && emcy_data_o[15:0] == `EC_LIFE
      && emcy_data_o[23:16] == `ER_COMM && emcy_data_o[39:32] == 8'h05)
    else $error("heartbeat failure frame wrong");

  err_react_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (|fail_set) |=> err_outputs_o ##1 !err_outputs_o || $past(err_act))
    else $error("error outputs not driven on timeout");

  blink_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hb_blink_o |-> failed_reg[last_reg])
    else $error("blink without failed last node");

  guard_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(prod_time) != 16'h0000 |-> !guarding_en_o)
    else $error("guarding enabled with heartbeat");

  emcy_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    emcy_valid_o && !emcy_ready_i |=> emcy_valid_o && $stable(emcy_data_o))
    else $error("emergency frame dropped or changed");

  modbus_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    evt_i.modbus_err |=> state_reg == ST_STOP)
    else $error("module bus error did not stop node");

  bus_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !hreadyout_o |=> hreadyout_o)
    else $error("bus wait longer than one cycle");
endmodule : hb_emcy

// [tb/hb_partner.sv]
`timescale 1ns/1ps
module hb_partner (
  input  wire logic        clk_i,
  input  wire logic        hb_tx_valid_i,
  input  wire logic [7:0]  hb_tx_state_i,
  output logic             hb_tx_ready_o,
  input  wire logic        emcy_valid_i,
  input  wire logic [63:0] emcy_data_i,
  output logic             emcy_ready_o,
  output logic             hb_rx_valid_o,
  output logic [6:0]       hb_rx_node_o
);
  int          lag = 0;
  int          ew = 0;
  int          hb_seen = 0;
  logic [7:0]  hb_last;
  logic [63:0] frames[$];

  initial begin
    hb_tx_ready_o = 1'b0;
    emcy_ready_o  = 1'b0;
    hb_rx_valid_o = 1'b0;
    hb_rx_node_o  = 7'h55;
  end

  // ==========================================
  // Heartbeat consumer, prompt
  always @(posedge clk_i) begin
    if (hb_tx_valid_i && hb_tx_ready_o) begin
      hb_seen++;
      hb_last = hb_tx_state_i;
    end
    hb_tx_ready_o <= hb_tx_valid_i && !hb_tx_ready_o;
  end

  // ==========================================
  // Emergency consumer, lag cycles slow
  always @(posedge clk_i) begin
    if (emcy_valid_i && emcy_ready_o) begin
      frames.push_back(emcy_data_i);
      emcy_ready_o <= 1'b0;
      ew = 0;
    end else if (emcy_valid_i) begin
      emcy_ready_o <= (ew >= lag);
      ew++;
    end
  end

  // ==========================================
  // Remote heartbeat, node line scrambled after
  task automatic send_hb(input logic [6:0] node);
    @(posedge clk_i);
    hb_rx_valid_o <= 1'b1;
    hb_rx_node_o  <= node;
    @(posedge clk_i);
    hb_rx_valid_o <= 1'b0;
    hb_rx_node_o  <= ~node;
  endtask : send_hb
endmodule : hb_partner

// [tb/hb_emcy_tb.sv]
`timescale 1ns/1ps
`include "hbm_cfg.svh"
module hb_emcy_tb;
  import hbm_pkg::*;
  // ==========================================
  // Signals
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  ahb_req_t    req       = '0;
  ahb_req_t    ahb;
  logic [31:0] hwdata    = '0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, rx_v, tx_v, tx_rdy, em_v, em_rdy, err_o, blink, guard;
  logic [6:0]  rx_node;
  logic [7:0]  tx_st;
  logic [63:0] em_d;
  logic [1:0]  nmt_st;
  logic        nmt_v     = 1'b0;
  nmt_state_t  nmt_c     = ST_PREOP;
  emcy_evt_t   evt       = '0;
  emcy_info_t  info;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          err_cnt = 0;
  int          e0;

  assign ahb = '{req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, hready};
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (err_o === 1'b1) err_cnt++;

  hb_emcy #(.TICK_CYCLES(4), .NODES(5)) hb_emcy_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ahb_i(ahb), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .hb_rx_valid_i(rx_v),
    .hb_rx_node_i(rx_node), .hb_tx_valid_o(tx_v), .hb_tx_state_o(tx_st),
    .hb_tx_ready_i(tx_rdy), .evt_i(evt), .info_i(info), .emcy_valid_o(em_v),
    .emcy_data_o(em_d), .emcy_ready_i(em_rdy), .nmt_cmd_valid_i(nmt_v), .nmt_cmd_i(nmt_c),
    .nmt_state_o(nmt_st), .err_outputs_o(err_o), .hb_blink_o(blink), .guarding_en_o(guard));

  hb_partner hb_partner_inst (
    .clk_i(clk_i), .hb_tx_valid_i(tx_v), .hb_tx_state_i(tx_st), .hb_tx_ready_o(tx_rdy),
    .emcy_valid_i(em_v), .emcy_data_i(em_d), .emcy_ready_o(em_rdy),
    .hb_rx_valid_o(rx_v), .hb_rx_node_o(rx_node));

  // ==========================================
  // Helpers
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) num_errors++;
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    req.hsel   <= 1'b1;
    req.haddr  <= a;
    req.htrans <= 2'b10;
    req.hwrite <= wr;
    req.hsize  <= 3'b010;
    wait_rdy();
    req.hsel   <= 1'b0;
    req.htrans <= 2'b00;
    hwdata     <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 64'(0), 64'(hresp));
  endtask : bus

  function automatic logic [63:0] fr(input logic [15:0] c, input logic [7:0] r,
                                     input logic [39:0] a);
    return {a[7:0], a[15:8], a[23:16], a[31:24], a[39:32], r, c};
  endfunction : fr

  task automatic expect_emcy(input logic [63:0] exp);
    logic [63:0] got;
    for (int n = 0; n < 300 && hb_partner_inst.frames.size() == 0; n++) @(posedge clk_i);
    got = 'x;
    if (hb_partner_inst.frames.size() != 0) got = hb_partner_inst.frames.pop_front();
    chk("emcy_data", exp, got);
  endtask : expect_emcy

  task automatic expect_hb(input logic [7:0] exp);
    int base;
    base = hb_partner_inst.hb_seen;
    for (int n = 0; n < 12 && hb_partner_inst.hb_seen == base; n++) @(posedge clk_i);
    chk("hb_state", 64'(exp), hb_partner_inst.hb_seen == base ? 64'hx : 64'(hb_partner_inst.hb_last));
  endtask : expect_hb

  task automatic nmt(input nmt_state_t s);
    nmt_v <= 1'b1;
    nmt_c <= s;
    @(posedge clk_i);
    nmt_v <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask : nmt

  // ==========================================
  // Scenarios
  task automatic test_reset();
    chk("guarding", 64'(1), 64'(guard));
    chk("hb_state", 64'(8'h7F), 64'(tx_st));
    bus(1'b0, `REG_STATUS, '0);
    chk("status", 64'(32'h0100_007F), 64'(rd));
    bus(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    bus(1'b0, 12'h0FC, '0);
    chk("unmapped", 64'(0), 64'(rd));
    repeat (20) @(posedge clk_i);
    chk("hb_count", 64'(0), 64'(hb_partner_inst.hb_seen));
  endtask : test_reset

  task automatic test_producer();
    bus(1'b1, `REG_CTRL, 32'h0000_0002);
    expect_hb(8'h7F);
    chk("guarding", 64'(0), 64'(guard));
    expect_hb(8'h7F);
    nmt(ST_OPER);
    expect_hb(8'h05);
    nmt(ST_STOP);
    expect_hb(8'h04);
  endtask : test_producer

  task automatic test_consumer();
    nmt(ST_OPER);
    bus(1'b1, `REG_CTRL, 32'h0002_0002);
    bus(1'b1, `REG_CONS_BASE, 32'h0003_0004);
    bus(1'b1, `REG_CONS_BASE + 12'h004, 32'h0009_0004);
    repeat (40) @(posedge clk_i);
    chk("idle_frames", 64'(0), 64'(hb_partner_inst.frames.size()));
    e0 = err_cnt;
    hb_partner_inst.send_hb(7'd3);
    expect_emcy(fr(16'h8130, 8'h11, 40'h0005030000));
    @(posedge clk_i);
    chk("blink", 64'(1), 64'(blink));
    chk("nmt_state", 64'(ST_STOP), 64'(nmt_st));
    chk("err_pulses", 64'(e0 + 1), 64'(err_cnt));
    hb_partner_inst.send_hb(7'd9);
    expect_emcy(fr(16'h8130, 8'h11, 40'h0005090000));
    hb_partner_inst.send_hb(7'd3);
    expect_emcy(fr(16'h0000, 8'h11, 40'h0005030000));
    chk("blink", 64'(1), 64'(blink));
    chk("nmt_state", 64'(ST_STOP), 64'(nmt_st));
    bus(1'b1, `REG_CONS_BASE, '0);
    hb_partner_inst.send_hb(7'd9);
    expect_emcy(fr(16'h0000, 8'h11, 40'h0005090000));
    @(posedge clk_i);
    chk("blink", 64'(0), 64'(blink));
    bus(1'b1, `REG_CONS_BASE + 12'h004, '0);
    repeat (40) @(posedge clk_i);
    hb_partner_inst.frames.delete();
  endtask : test_consumer

  function automatic logic [63:0] exp_ev(input int i);
    case (i)
      16: return fr(16'h5000, 8'h81, 40'h0001000000);
      15: return fr(16'h5000, 8'h81, 40'h0002000000);
      14: return fr(16'h5000, 8'h81, 40'h00030E0233);
      13: return fr(16'h5000, 8'h81, 40'h0009000000);
      12: return fr(16'h5000, 8'h81, 40'h000A010000);
      11: return fr(16'h5000, 8'h81, 40'h000A020000);
      10: return fr(16'h8100, 8'h81, 40'h0004000000);
      9: return fr(16'h0000, 8'h81, 40'h0004000000);
      8: return fr(16'h8110, 8'h11, 40'h0001000000);
      7: return fr(16'h8110, 8'h11, 40'h0002000000);
      6: return fr(16'h8120, 8'h11, 40'h0003000000);
      5: return fr(16'h8130, 8'h11, 40'h0004000000);
      4: return fr(16'h0000, 8'h11, 40'h0004000000);
      3: return fr(16'h8210, 8'h81, 40'h0005080511);
      2: return fr(16'h8220, 8'h81, 40'h0008080511);
      1: return fr(16'hFF00, 8'h81, 40'h00060E0000);
      default: return fr(16'hFF00, 8'h81, 40'h44070E2111);
    endcase
  endfunction : exp_ev

  task automatic test_events();
    bus(1'b1, `REG_CTRL, 32'h0000_0002);
    nmt(ST_OPER);
    hb_partner_inst.lag = 3;
    for (int i = 16; i >= 0; i--) begin
      if (i == 7) begin
        bus(1'b1, `REG_CTRL, 32'h0001_0002);
        nmt(ST_OPER);
      end
      e0 = err_cnt;
      info <= 64'h0E02_3308_0511_4421;
      evt <= emcy_evt_t'(17'h1 << i);
      @(posedge clk_i);
      evt <= '0;
      info <= '1;
      expect_emcy(exp_ev(i));
      if (i == 7) begin
        chk("nmt_state", 64'(ST_OPER), 64'(nmt_st));
        chk("err_pulses", 64'(e0 + 1), 64'(err_cnt));
      end
      if (i == 8) begin
        chk("nmt_state", 64'(ST_PREOP), 64'(nmt_st));
        chk("err_pulses", 64'(e0 + 1), 64'(err_cnt));
      end
      if (i == 1) chk("nmt_state", 64'(ST_STOP), 64'(nmt_st));
    end
  endtask : test_events

  // ==========================================
  // Run control
  task automatic end_of_test();
    $display("num_errors=%0d samples_checked=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    #(25 * 20000);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_producer();
    test_consumer();
    test_events();
    end_of_test();
  end
endmodule : hb_emcy_tb
